// *** core/spm_pkg.sv ***
// Purpose: constants and carriers for the strap and pin-mux block
// Assumes: byte registers on a plain strobe port
// Notes:   offsets chosen locally
`default_nettype none
package spm_pkg;
   localparam logic [3:0] SPM_OFS_STRAP  = 4'h0;
   localparam logic [3:0] SPM_OFS_MODULE_CONFIGURATION   = 4'h4;
   localparam logic [3:0] SPM_OFS_PAGE   = 4'h8;
   localparam logic [3:0] SPM_OFS_PORT_B_ALT_SELECT  = 4'hC;
   localparam logic [3:0] SPM_OFS_PORT_C_ALT_SELECT  = 4'h1;
   localparam logic [3:0] SPM_OFS_PORT_D_ALT_SELECT  = 4'h2;
   localparam logic [3:0] SPM_OFS_PORT_E_ALT_SELECT  = 4'h3;
   // module configuration bit positions
   localparam int SPM_SHADOW_OFF = 0;
   localparam int SPM_SHMEN = 1;
   localparam int SPM_EXW   = 2;
   localparam int SPM_ADDR_BIT15_OUT_EN  = 3;
   localparam int SPM_IOE   = 4;
   localparam int SPM_CLOCK_OUT_EN = 5;
   localparam int SPM_TEST  = 6;
   localparam logic [7:0] SPM_MODULE_CONFIGURATION_WMASK = 8'h3F;
   localparam logic [7:0] SPM_MODULE_CONFIGURATION_RST   = 8'h00;
   localparam logic [7:0] SPM_PAGE_RST   = 8'h00;
   localparam logic [7:0] SPM_ALT_RST    = 8'h00;
   localparam logic [2:0] SPM_PAGE_MASK  = 3'h7;

   typedef enum logic [1:0] {SPM_ONCHIP, SPM_OFFCHIP, SPM_DEV, SPM_BAD}
      spm_env_e;

   typedef struct packed {
      logic       env_sel0;
      logic       env_zone1_select;
      logic       float_all_strap;
      logic       host_reset_mode_strap;
      logic       host_enable_strap;
      logic       shared_bios_strap;
      logic [2:0] addr_straps;
   } spm_strap_s;

   typedef struct packed {
      logic [6:0] port_a;
      logic [7:0] port_b;
      logic [7:0] port_c;
      logic [7:0] port_d;
      logic [1:0] port_e;
      logic [7:0] port_f;
      logic [4:0] port_g;
      logic [5:0] port_h;
   } spm_pins_s;

   typedef struct packed {
      logic       latched;
      spm_strap_s strap;
      logic [7:0] module_configuration;
      logic [7:0] page;
      logic [7:0] pb_alt;
      logic [7:0] pc_alt;
      logic [7:0] pd_alt;
      logic [7:0] pe_alt;
      logic [7:0] rdata;
      spm_pins_s  alt_sel;
      logic       pin_float;
      logic [2:0] page_out;
      logic [2:0] idle_addr;
      logic       idle_drive;
      logic       host_reset_evt;
      logic       host_stretch;
      logic       host_if_en;
      logic       host_mem_ok;
      logic       ext_mem_en;
      logic       base_shadow;
   } spm_state_s;
endpackage
`default_nettype wire

// *** core/spm_top.sv ***
// Purpose: strap capture, system configuration and pin function select
// Assumes: por_n low during power-up reset only; straps valid then
// Notes:   alt_sel bit high means pin carries its alternate function
`default_nettype none
module spm_top
   import spm_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              por_n,
   input  wire logic              clk_en,
   input  wire spm_strap_s        strap_in,
   input  wire logic              active_mode,
   input  wire logic              test_hook,
   input  wire logic              host_access,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   output var spm_pins_s          alt_sel,
   output logic                   pin_float,
   output logic [2:0]             page_out,
   output logic [2:0]             idle_addr,
   output logic                   idle_drive,
   output logic                   host_reset_evt,
   output logic                   host_stretch,
   output logic                   host_if_en,
   output logic                   host_mem_ok,
   output logic                   ext_mem_en,
   output logic                   base_shadow
);
   // offsets are four bits wide, so the address must be too
   if (ADDR_W != 4) begin : g_addr_check
      $error("spm_top: ADDR_W must be 4");
   end

   spm_state_s st;
   spm_state_s next_st;
   spm_env_e   env;
   logic       sharing;
   logic       alt_wide;
   logic       module_configuration_hit;

   default clocking chk_clk @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   always_comb begin
      env      = spm_env_e'({st.strap.env_sel0, st.strap.env_zone1_select});
      sharing  = ~st.strap.shared_bios_strap;
      module_configuration_hit = hit(reg_addr, SPM_OFS_MODULE_CONFIGURATION);
      next_st  = st;
      if (!por_n) begin
         next_st.strap   = strap_in;
         next_st.latched = 1'b1;
      end
      if (reg_wr && module_configuration_hit && active_mode) begin
         next_st.module_configuration = (reg_wdata & SPM_MODULE_CONFIGURATION_WMASK)
                        | (st.module_configuration & ~SPM_MODULE_CONFIGURATION_WMASK);
      end
      if (st.latched && sharing) begin
         next_st.module_configuration[SPM_ADDR_BIT15_OUT_EN] = 1'b1;
      end
      next_st.module_configuration[SPM_TEST] = test_hook;
      next_st.module_configuration[7]        = 1'b0;
      if (reg_wr && hit(reg_addr, SPM_OFS_PAGE)) begin
         next_st.page = {5'h00, reg_wdata[2:0] & SPM_PAGE_MASK};
      end
      if (reg_wr && hit(reg_addr, SPM_OFS_PORT_B_ALT_SELECT)) next_st.pb_alt = reg_wdata;
      if (reg_wr && hit(reg_addr, SPM_OFS_PORT_C_ALT_SELECT)) next_st.pc_alt = reg_wdata;
      if (reg_wr && hit(reg_addr, SPM_OFS_PORT_D_ALT_SELECT)) next_st.pd_alt = reg_wdata;
      if (reg_wr && hit(reg_addr, SPM_OFS_PORT_E_ALT_SELECT)) next_st.pe_alt = reg_wdata;
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            SPM_OFS_STRAP: next_st.rdata = {5'h00,
                              st.strap.host_enable_strap,
                              st.strap.host_reset_mode_strap,
                              st.strap.shared_bios_strap};
            SPM_OFS_MODULE_CONFIGURATION:  next_st.rdata = st.module_configuration;
            SPM_OFS_PAGE:  next_st.rdata = st.page;
            SPM_OFS_PORT_B_ALT_SELECT: next_st.rdata = st.pb_alt;
            SPM_OFS_PORT_C_ALT_SELECT: next_st.rdata = st.pc_alt;
            SPM_OFS_PORT_D_ALT_SELECT: next_st.rdata = st.pd_alt;
            SPM_OFS_PORT_E_ALT_SELECT: next_st.rdata = st.pe_alt;
            default:       next_st.rdata = 8'h00;
         endcase
      end
      next_st.alt_sel.port_a = sharing ? 7'h7F : 7'h00;
      next_st.alt_sel.port_b = st.pb_alt;
      next_st.alt_sel.port_b[5] = 1'b0;
      next_st.alt_sel.port_b[6] = 1'b1;
      next_st.alt_sel.port_c = st.pc_alt;
      next_st.alt_sel.port_d = st.pd_alt;
      next_st.alt_sel.port_e = st.pe_alt[1:0];
      alt_wide = (env != SPM_ONCHIP) || st.module_configuration[SPM_EXW];
      next_st.alt_sel.port_f = alt_wide ? 8'hFF : 8'h00;
      next_st.alt_sel.port_g[3] = alt_wide;
      next_st.alt_sel.port_g[4] = alt_wide;
      next_st.alt_sel.port_g[0] = (env != SPM_ONCHIP) || st.module_configuration[SPM_IOE];
      next_st.alt_sel.port_g[1] = (env != SPM_ONCHIP) || st.module_configuration[SPM_ADDR_BIT15_OUT_EN];
      next_st.alt_sel.port_g[2] = (env != SPM_ONCHIP) || st.module_configuration[SPM_CLOCK_OUT_EN];
      next_st.alt_sel.port_h = (env == SPM_DEV) ? 6'h3F : 6'h00;
      next_st.pin_float = st.strap.float_all_strap;
      next_st.page_out = (sharing && !host_access) ? st.page[2:0] : 3'h0;
      next_st.idle_drive = sharing && !active_mode;
      next_st.idle_addr  = st.strap.addr_straps;
      next_st.ext_mem_en  = st.module_configuration[SPM_SHADOW_OFF];
      next_st.base_shadow = ~st.module_configuration[SPM_SHADOW_OFF];
      next_st.host_mem_ok = sharing && st.module_configuration[SPM_SHADOW_OFF]
                            && st.module_configuration[SPM_SHMEN] && active_mode;
      next_st.host_stretch   = sharing && host_access
                               && !st.strap.host_reset_mode_strap
                               && !next_st.host_mem_ok;
      next_st.host_reset_evt = sharing && host_access
                               && st.strap.host_reset_mode_strap
                               && !next_st.host_mem_ok;
      next_st.host_if_en = st.strap.host_enable_strap;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st        <= '0;
         st.module_configuration   <= SPM_MODULE_CONFIGURATION_RST;
         st.page   <= SPM_PAGE_RST;
         st.pb_alt <= SPM_ALT_RST;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign reg_rdata      = st.rdata;
   assign alt_sel        = st.alt_sel;
   assign pin_float      = st.pin_float;
   assign page_out       = st.page_out;
   assign idle_addr      = st.idle_addr;
   assign idle_drive     = st.idle_drive;
   assign host_reset_evt = st.host_reset_evt;
   assign host_stretch   = st.host_stretch;
   assign host_if_en     = st.host_if_en;
   assign host_mem_ok    = st.host_mem_ok;
   assign ext_mem_en     = st.ext_mem_en;
   assign base_shadow    = st.base_shadow;

   chk_b5_gpio: assert property (
      !alt_sel.port_b[5]
   ) else $error("B5 took alternate");

   chk_b6_alt: assert property (
      clk_en |=> alt_sel.port_b[6]
   ) else $error("B6 not host reset");

   chk_module_configuration_hold: assert property (
      (clk_en && !active_mode && por_n) |=>
      $stable({st.module_configuration[5:4], st.module_configuration[2:0]})
      && (st.module_configuration[SPM_ADDR_BIT15_OUT_EN] || !$past(st.module_configuration[SPM_ADDR_BIT15_OUT_EN]))
   ) else $error("config changed in idle");

   chk_test_flag: assert property (
      clk_en |=> st.module_configuration[SPM_TEST] == $past(test_hook)
   ) else $error("test flag wrong");

   chk_strap_keep: assert property (
      (por_n && clk_en) |=> $stable(st.strap)
   ) else $error("straps moved");

   chk_host_gate: assert property (
      host_mem_ok |-> $past(st.module_configuration[SPM_SHADOW_OFF] && st.module_configuration[SPM_SHMEN])
   ) else $error("host access without both bits");

   chk_port_h: assert property (
      (clk_en && env != SPM_DEV) |=> alt_sel.port_h == 6'h00
   ) else $error("port H alternate outside dev");

   chk_float: assert property (
      clk_en |=> pin_float == $past(st.strap.float_all_strap)
   ) else $error("float mismatch");

   chk_host_mode: assert property (
      !(host_reset_evt && host_stretch)
   ) else $error("both host modes");

   chk_port_a_sel: assert property (
      clk_en |=> (alt_sel.port_a == 7'h7F)
      == !$past(st.strap.shared_bios_strap)
   ) else $error("port A select wrong");

   // port B free bits follow select
   chk_port_b_sel: assert property (
      clk_en |=> {alt_sel.port_b[7], alt_sel.port_b[4:0]}
      == $past({st.pb_alt[7], st.pb_alt[4:0]})
   ) else $error("port B select wrong");

   chk_port_c_sel: assert property (
      clk_en |=> alt_sel.port_c == $past(st.pc_alt)
   ) else $error("port C select wrong");

   chk_port_d_sel: assert property (
      clk_en |=> alt_sel.port_d == $past(st.pd_alt)
   ) else $error("port D select wrong");

   chk_port_e_sel: assert property (
      clk_en |=> alt_sel.port_e == $past(st.pe_alt[1:0])
   ) else $error("port E select wrong");

   // port F gpio in narrow on-chip
   chk_port_f_gpio: assert property (
      (clk_en && env == SPM_ONCHIP && !st.module_configuration[SPM_EXW])
      |=> alt_sel.port_f == 8'h00
   ) else $error("port F alternate in narrow on-chip");

   chk_port_f_ext: assert property (
      (clk_en && env != SPM_ONCHIP) |=> alt_sel.port_f == 8'hFF
   ) else $error("port F not data off-chip");

   chk_port_g_ext: assert property (
      (clk_en && env != SPM_ONCHIP) |=> alt_sel.port_g == 5'h1F
   ) else $error("port G not alternate off-chip");

   chk_port_h_dev: assert property (
      (clk_en && env == SPM_DEV) |=> alt_sel.port_h == 6'h3F
   ) else $error("port H gpio in dev");

   chk_status_rd: assert property (
      (clk_en && reg_rd && reg_addr == SPM_OFS_STRAP) |=>
      reg_rdata == {5'h00, $past({st.strap.host_enable_strap,
      st.strap.host_reset_mode_strap, st.strap.shared_bios_strap})}
   ) else $error("status read wrong");

   // read data only after a read
   chk_rdata_idle: assert property (
      (clk_en && !reg_rd) |=> reg_rdata == 8'h00
   ) else $error("read data without read");

   chk_module_configuration_resv: assert property (
      !st.module_configuration[7]
   ) else $error("reserved config bit set");

   chk_page_host: assert property (
      (clk_en && host_access) |=> page_out == 3'h0
   ) else $error("page driven during host access");

   chk_page_core: assert property (
      (clk_en && !host_access && !st.strap.shared_bios_strap)
      |=> page_out == $past(st.page[2:0])
   ) else $error("page bits not driven");

   chk_ext_mem: assert property (
      clk_en |=> ext_mem_en == $past(st.module_configuration[SPM_SHADOW_OFF])
      && base_shadow == !ext_mem_en
   ) else $error("shadow state wrong");

   chk_idle_drive: assert property (
      clk_en |=> idle_drive
      == $past(!st.strap.shared_bios_strap && !active_mode)
   ) else $error("idle drive wrong");

   chk_idle_addr: assert property (
      clk_en |=> idle_addr == $past(st.strap.addr_straps)
   ) else $error("idle address wrong");

   chk_host_en: assert property (
      clk_en |=> host_if_en == $past(st.strap.host_enable_strap)
   ) else $error("host enable wrong");

   chk_a15_forced: assert property (
      (clk_en && st.latched && !st.strap.shared_bios_strap)
      |=> st.module_configuration[SPM_ADDR_BIT15_OUT_EN]
   ) else $error("address 15 bit not forced");

   // reset event only in reset mode
   chk_reset_evt: assert property (
      host_reset_evt |-> $past(st.strap.host_reset_mode_strap)
   ) else $error("reset event in stretch mode");

   chk_host_active: assert property (
      (clk_en && !active_mode) |=> !host_mem_ok
   ) else $error("host access outside active");
endmodule
`default_nettype wire

// *** dv/spm_strap_board.sv ***
// Purpose: board strap resistors seen by the strap capture
// Assumes: straps are driven only inside the power-up window
// Notes:   outside the window the shared pins carry other traffic
`default_nettype none
module spm_strap_board
   import spm_pkg::*;
(
   input  wire logic       por_n,
   input  wire spm_strap_s board_cfg,
   output var spm_strap_s  strap_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // board levels in window
   // outside the window the pins toggle away from the strapped value
   assign strap_in = por_n ? spm_strap_s'(~board_cfg) : board_cfg;
endmodule
`default_nettype wire

// *** dv/tb_strap_pinmux_sysconfig.sv ***
// Purpose: register and pin select checks for the strap block
// Assumes: straps latched while por_n is low after rst_n release
// Notes:   derived outputs checked a few cycles after each write
`default_nettype none
module tb_strap_pinmux_sysconfig
   import spm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk, rst_n, por_n, clk_en, active_mode, test_hook;
   logic       host_access, reg_wr, reg_rd, pin_float, idle_drive;
   logic       host_reset_evt, host_stretch, host_if_en, host_mem_ok;
   logic       ext_mem_en, base_shadow;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic [2:0] page_out, idle_addr;
   spm_strap_s board_cfg, strap_in;
   spm_pins_s  alt_sel;
   int         err_total, cmp_count;
   spm_top i_spm_top (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n),
      .clk_en(clk_en), .strap_in(strap_in), .active_mode(active_mode),
      .test_hook(test_hook), .host_access(host_access),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alt_sel(alt_sel),
      .pin_float(pin_float), .page_out(page_out), .idle_addr(idle_addr),
      .idle_drive(idle_drive), .host_reset_evt(host_reset_evt),
      .host_stretch(host_stretch), .host_if_en(host_if_en),
      .host_mem_ok(host_mem_ok), .ext_mem_en(ext_mem_en),
      .base_shadow(base_shadow));
   spm_strap_board i_spm_strap_board (.por_n(por_n),
      .board_cfg(board_cfg), .strap_in(strap_in));
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 chk("rdata", e, reg_rdata);
   endtask
   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask
   task automatic pwr(input spm_strap_s c);
      @(posedge core_clk);
      board_cfg <= c;
      rst_n     <= 1'h0;
      por_n     <= 1'h0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge core_clk);
      por_n <= 1'h1;
      settle();
   endtask
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      end_of_test();
   end
   initial begin
      {rst_n, por_n, clk_en, active_mode, test_hook} = 5'h04;
      {host_access, reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0000;
      board_cfg = '0;
      err_total = 0;
      cmp_count = 0;
      // development env, reset event mode, host on, sharing on
      pwr('{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h5});
      rdc(SPM_OFS_STRAP, 8'h06);
      wr(SPM_OFS_STRAP, 8'hF9);
      rdc(SPM_OFS_STRAP, 8'h06);
      rdc(SPM_OFS_MODULE_CONFIGURATION, 8'h08);
      chk("idle_addr", 8'h05, {5'h00, idle_addr});
      chk("idle_drive", 8'h01, {7'h00, idle_drive});
      chk("host_if_en", 8'h01, {7'h00, host_if_en});
      chk("pin_float", 8'h00, {7'h00, pin_float});
      chk("port_a", 8'h7F, {1'h0, alt_sel.port_a});
      chk("port_h", 8'h3F, {2'h0, alt_sel.port_h});
      chk("port_f", 8'hFF, alt_sel.port_f);
      chk("port_g", 8'h1F, {3'h0, alt_sel.port_g});
      host_access <= 1'h1;
      wr(SPM_OFS_MODULE_CONFIGURATION, 8'h03);
      rdc(SPM_OFS_MODULE_CONFIGURATION, 8'h08);
      chk("reset_evt", 8'h01, {7'h00, host_reset_evt});
      chk("mem_ok", 8'h00, {7'h00, host_mem_ok});
      active_mode <= 1'h1;
      wr(SPM_OFS_MODULE_CONFIGURATION, 8'h03);
      rdc(SPM_OFS_MODULE_CONFIGURATION, 8'h0B);
      settle();
      chk("mem_ok", 8'h01, {7'h00, host_mem_ok});
      chk("reset_evt", 8'h00, {7'h00, host_reset_evt});
      chk("ext_mem", 8'h01, {7'h00, ext_mem_en});
      chk("shadow", 8'h00, {7'h00, base_shadow});
      chk("idle_drive", 8'h00, {7'h00, idle_drive});
      wr(SPM_OFS_PAGE, 8'hFF);
      rdc(SPM_OFS_PAGE, 8'h07);
      chk("page_host", 8'h00, {5'h00, page_out});
      host_access <= 1'h0;
      test_hook   <= 1'h1;
      settle();
      chk("page_out", 8'h07, {5'h00, page_out});
      rdc(SPM_OFS_MODULE_CONFIGURATION, 8'h4B);
      wr(SPM_OFS_PORT_B_ALT_SELECT, 8'hFF);
      wr(SPM_OFS_PORT_C_ALT_SELECT, 8'hA5);
      wr(SPM_OFS_PORT_D_ALT_SELECT, 8'h5A);
      wr(SPM_OFS_PORT_E_ALT_SELECT, 8'h02);
      settle();
      chk("port_b", 8'hDF, alt_sel.port_b);
      chk("port_c", 8'hA5, alt_sel.port_c);
      chk("port_d", 8'h5A, alt_sel.port_d);
      chk("port_e", 8'h02, {6'h00, alt_sel.port_e});
      wr(SPM_OFS_PORT_B_ALT_SELECT, 8'h00);
      settle();
      chk("port_b", 8'h40, alt_sel.port_b);
      test_hook <= 1'h0;
      // on-chip env, floating, stretch mode, host off, sharing off
      pwr('{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0});
      rdc(SPM_OFS_STRAP, 8'h01);
      rdc(SPM_OFS_MODULE_CONFIGURATION, 8'h00);
      chk("pin_float", 8'h01, {7'h00, pin_float});
      chk("host_if_en", 8'h00, {7'h00, host_if_en});
      chk("port_a", 8'h00, {1'h0, alt_sel.port_a});
      chk("port_h", 8'h00, {2'h0, alt_sel.port_h});
      host_access <= 1'h1;
      settle();
      chk("stretch", 8'h00, {7'h00, host_stretch});
      for (int i = 0; i < 4; i++) begin
         rv = 8'h01 << ((i == 3) ? 2 : i + 3);
         wr(SPM_OFS_MODULE_CONFIGURATION, rv);
         settle();
         rv = (i == 3) ? 8'h18 : (i == 0) ? 8'h02
              : (i == 1) ? 8'h01 : 8'h04;
         chk("port_g", rv, {3'h0, alt_sel.port_g});
         chk("port_f", (i == 3) ? 8'hFF : 8'h00, alt_sel.port_f);
      end
      // on-chip env, stretch mode, sharing on, idle
      pwr('{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0});
      active_mode <= 1'h0;
      settle();
      chk("stretch", 8'h01, {7'h00, host_stretch});
      chk("reset_evt", 8'h00, {7'h00, host_reset_evt});
      end_of_test();
   end
endmodule
`default_nettype wire
